// ==== src/tbcp_params.svh ====
// Constants for the timer block clock prescaler: addresses, field masks, reset values, counts
`ifndef TBCP_PARAMS_SVH
`define TBCP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TBCP_ADDR_AUX_COUNT   16'hfe46
`define TBCP_ADDR_CORE_COUNT  16'hfe48
`define TBCP_ADDR_AUX_CTRL    16'hfe40
`define TBCP_ADDR_CORE_CTRL   16'hfe42
`define TBCP_ADDR_STATUS      16'hfe44

// ----------------------------------------------------------------------------
// Writable bits and reset values
// ----------------------------------------------------------------------------
`define TBCP_AUX_CTRL_WMASK   16'h077f
`define TBCP_CORE_CTRL_WMASK  16'h197f
`define TBCP_CTRL_RESET       16'h0000
`define TBCP_COUNT_RESET      16'h0000
`define TBCP_READ_IDLE        16'h0000

// ----------------------------------------------------------------------------
// Block prescale codes and terminal counts (factor minus one)
// ----------------------------------------------------------------------------
`define TBCP_BPS_DIV2         2'h1
`define TBCP_BPS_DIV4         2'h0
`define TBCP_BPS_DIV8         2'h3
`define TBCP_BPS_DIV16        2'h2
`define TBCP_LAST_DIV2        4'h1
`define TBCP_LAST_DIV4        4'h3
`define TBCP_LAST_DIV8        4'h7
`define TBCP_LAST_DIV16       4'hf

`endif

// ==== src/tbcp_pkg.sv ====
// Types shared by the timer block clock prescaler modules
package tbcp_pkg;

   typedef enum logic [1:0] {
      TBCP_MODE_TIMER    = 2'b00,
      TBCP_MODE_COUNTER  = 2'b01,
      TBCP_MODE_GATED_LO = 2'b10,
      TBCP_MODE_GATED_HI = 2'b11
   } tbcp_mode_e;

   // Timer control word, 16 bits
   typedef struct packed {
      logic [2:0] rsv_hi;
      logic [1:0] block_prescale_select;
      logic [1:0] capture_edge;
      logic       run;
      logic       rsv_lo;
      logic [1:0] edge_sel;
      tbcp_mode_e mode;
      logic [2:0] timer_input_prescale;
   } tbcp_ctrl_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } tbcp_req_s;

   typedef struct packed {
      logic rise;
      logic fall;
      logic level;
   } tbcp_edge_s;

endpackage

// ==== src/tbcp_block_prescaler.sv ====
// Block prescaler: one-cycle basic clock tick from the module clock
`timescale 1ns/1ps
`default_nettype none
`include "tbcp_params.svh"
module tbcp_block_prescaler
   import tbcp_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       ce,
   input  wire logic [1:0] block_prescale_select,
   output logic            basic_tick
);

   logic [3:0] cnt_r;
   logic [3:0] last;

   // Non-linear code
   function automatic logic [3:0] bps_last(input logic [1:0] sel);
      logic [3:0] l;
      l = `TBCP_LAST_DIV4;
      unique case (sel)
         `TBCP_BPS_DIV2:  l = `TBCP_LAST_DIV2;
         `TBCP_BPS_DIV4:  l = `TBCP_LAST_DIV4;
         `TBCP_BPS_DIV8:  l = `TBCP_LAST_DIV8;
         `TBCP_BPS_DIV16: l = `TBCP_LAST_DIV16;
      endcase
      return l;
   endfunction

   assign last = bps_last(block_prescale_select);

   // A shrinking factor can leave the count above the end; wrap at once
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_r      <= 4'h0;
         basic_tick <= 1'b0;
      end
      else if (ce)
      begin
         if (cnt_r >= last)
         begin
            cnt_r      <= 4'h0;
            basic_tick <= 1'b1;
         end
         else
         begin
            cnt_r      <= cnt_r + 4'h1;
            basic_tick <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ==== src/tbcp_edge_sampler.sv ====
// Input synchroniser, basic-clock sampler and transition detector
`timescale 1ns/1ps
`default_nettype none
module tbcp_edge_sampler
   import tbcp_pkg::*;
#(
   parameter int unsigned WIDTH = 3
)
(
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             sample_en,
   input  wire logic [WIDTH-1:0] pins,
   output tbcp_edge_s            edges [WIDTH]
);

   logic [WIDTH-1:0] sync1_r;
   logic [WIDTH-1:0] sync2_r;
   logic [WIDTH-1:0] samp_r;
   logic             primed_r;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else if (ce)
      begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
      end
   end

   // No edge until a first real sample exists
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         samp_r   <= '0;
         primed_r <= 1'b0;
      end
      else if (ce && sample_en)
      begin
         samp_r   <= sync2_r;
         primed_r <= 1'b1;
      end
   end

   for (genvar i = 0; i < WIDTH; i++)
   begin : g_bit
      always_ff @(posedge clk or negedge rst_n)
      begin
         if (!rst_n)
            edges[i] <= '0;
         else if (ce)
         begin
            edges[i].level <= samp_r[i];
            edges[i].rise  <= sample_en & primed_r & sync2_r[i] & ~samp_r[i];
            edges[i].fall  <= sample_en & primed_r & ~sync2_r[i] & samp_r[i];
         end
      end
   end

endmodule
`default_nettype wire

// ==== src/tbcp_top.sv ====
// Timer block clock front end: registers, prescalers and count clock selection
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "tbcp_params.svh"
module tbcp_top
   import tbcp_pkg::*;
#(
   parameter int unsigned DIV_W = 7
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire tbcp_req_s   bus_req,
   input  wire logic        aux_in,
   input  wire logic        core_in,
   input  wire logic        capture_in,
   output logic [15:0]      rd_data,
   output logic             basic_tick_o,
   output logic             aux_count_tick,
   output logic             core_count_tick,
   output logic             aux_edge_event,
   output logic             core_edge_event,
   output logic             capture_event
);

   // ----------------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------------
   tbcp_ctrl_s       aux_ctrl_r;
   tbcp_ctrl_s       core_ctrl_r;
   logic [15:0]      aux_count_r;
   logic [15:0]      core_count_r;
   logic [DIV_W-1:0] aux_div_r;
   logic [DIV_W-1:0] core_div_r;
   logic             basic_tick;
   tbcp_edge_s       edges [3];
   logic             aux_int_tick;
   logic             core_int_tick;
   logic             aux_tick_nxt;
   logic             core_tick_nxt;
   logic             aux_edge_nxt;
   logic             core_edge_nxt;
   logic             capture_nxt;
   logic [15:0]      status;

   localparam int unsigned PIN_AUX  = 0;
   localparam int unsigned PIN_CORE = 1;
   localparam int unsigned PIN_CAP  = 2;

   // ----------------------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------------------

   // Low input-prescale bits of the divider chain that must all be set
   function automatic logic [DIV_W-1:0] prescale_mask(input logic [2:0] sel);
      logic [DIV_W-1:0] ones;
      ones = '1;
      return ~(ones << sel);
   endfunction

   // Divider reaches the end of a 2^sel basic-clock period
   function automatic logic prescale_hit(input logic [DIV_W-1:0] div,
                                         input logic [2:0]       sel);
      logic [DIV_W-1:0] m;
      m = prescale_mask(sel);
      return (div & m) == m;
   endfunction

   // Edge selection: bit 0 rising, bit 1 falling
   function automatic logic edge_hit(input logic [1:0] sel,
                                     input tbcp_edge_s e);
      return (sel[0] & e.rise) | (sel[1] & e.fall);
   endfunction

   // Count clock of one timer from its mode
   function automatic logic count_select(input tbcp_ctrl_s c,
                                         input logic       int_tick,
                                         input tbcp_edge_s e);
      logic t;
      t = 1'b0;
      unique case (c.mode)
         TBCP_MODE_TIMER:    t = int_tick;
         TBCP_MODE_GATED_LO: t = int_tick & ~e.level;
         TBCP_MODE_GATED_HI: t = int_tick & e.level;
         TBCP_MODE_COUNTER:  t = edge_hit(c.edge_sel, e);
      endcase
      return t & c.run;
   endfunction

   // ----------------------------------------------------------------------------
   // Basic clock and input sampling
   // ----------------------------------------------------------------------------
   tbcp_block_prescaler u_block_prescaler (
      .clk                   (clk),
      .rst_n                 (rst_n),
      .ce                    (ce),
      .block_prescale_select (core_ctrl_r.block_prescale_select),
      .basic_tick            (basic_tick)
   );

   tbcp_edge_sampler #(
      .WIDTH (3)
   ) u_edge_sampler (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .sample_en (basic_tick),
      .pins      ({capture_in, core_in, aux_in}),
      .edges     (edges)
   );

   // ----------------------------------------------------------------------------
   // Per-timer input prescalers
   // ----------------------------------------------------------------------------

   // Free-running dividers: a prescale change takes effect mid-period
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         aux_div_r <= '0;
      else if (ce && basic_tick)
         aux_div_r <= aux_div_r + {{(DIV_W-1){1'b0}}, 1'b1};
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         core_div_r <= '0;
      else if (ce && basic_tick)
         core_div_r <= core_div_r + {{(DIV_W-1){1'b0}}, 1'b1};
   end

   assign aux_int_tick  = basic_tick & prescale_hit(aux_div_r, aux_ctrl_r.timer_input_prescale);
   assign core_int_tick = basic_tick & prescale_hit(core_div_r, core_ctrl_r.timer_input_prescale);

   // ----------------------------------------------------------------------------
   // Count clock selection and events
   // ----------------------------------------------------------------------------
   assign aux_tick_nxt  = count_select(aux_ctrl_r, aux_int_tick, edges[PIN_AUX]);
   assign core_tick_nxt = count_select(core_ctrl_r, core_int_tick, edges[PIN_CORE]);
   assign aux_edge_nxt  = edge_hit(aux_ctrl_r.edge_sel, edges[PIN_AUX]);
   assign core_edge_nxt = edge_hit(core_ctrl_r.edge_sel, edges[PIN_CORE]);
   assign capture_nxt   = edge_hit(aux_ctrl_r.capture_edge, edges[PIN_CAP]);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_count_tick  <= 1'b0;
         core_count_tick <= 1'b0;
      end
      else if (ce)
      begin
         aux_count_tick  <= aux_tick_nxt;
         core_count_tick <= core_tick_nxt;
      end
   end

   // One module-clock pulse per detected transition
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aux_edge_event  <= 1'b0;
         core_edge_event <= 1'b0;
         capture_event   <= 1'b0;
      end
      else if (ce)
      begin
         aux_edge_event  <= aux_edge_nxt;
         core_edge_event <= core_edge_nxt;
         capture_event   <= capture_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         basic_tick_o <= 1'b0;
      else if (ce)
         basic_tick_o <= basic_tick;
   end

   // ----------------------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         aux_ctrl_r <= tbcp_ctrl_s'(`TBCP_CTRL_RESET);
      else if (ce && bus_req.wr && bus_req.addr == `TBCP_ADDR_AUX_CTRL)
         aux_ctrl_r <= tbcp_ctrl_s'(bus_req.wdata & `TBCP_AUX_CTRL_WMASK);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         core_ctrl_r <= tbcp_ctrl_s'(`TBCP_CTRL_RESET);
      else if (ce && bus_req.wr && bus_req.addr == `TBCP_ADDR_CORE_CTRL)
         core_ctrl_r <= tbcp_ctrl_s'(bus_req.wdata & `TBCP_CORE_CTRL_WMASK);
   end

   // ----------------------------------------------------------------------------
   // Count registers
   // ----------------------------------------------------------------------------

   // A software write in the same cycle as a tick wins; the tick is dropped
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         aux_count_r <= `TBCP_COUNT_RESET;
      else if (ce)
      begin
         if (bus_req.wr && bus_req.addr == `TBCP_ADDR_AUX_COUNT)
            aux_count_r <= bus_req.wdata;
         else if (aux_count_tick)
            aux_count_r <= aux_count_r + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         core_count_r <= `TBCP_COUNT_RESET;
      else if (ce)
      begin
         if (bus_req.wr && bus_req.addr == `TBCP_ADDR_CORE_COUNT)
            core_count_r <= bus_req.wdata;
         else if (core_count_tick)
            core_count_r <= core_count_r + 16'h0001;
      end
   end

   // ----------------------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------------------

   // Sampled pin levels, as the timers see them
   assign status = {13'h0000,
                    edges[PIN_CAP].level,
                    edges[PIN_CORE].level,
                    edges[PIN_AUX].level};

   // Data stands only in the cycle after the read strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_data <= `TBCP_READ_IDLE;
      else if (ce)
      begin
         if (bus_req.rd)
         begin
            unique case (bus_req.addr)
               `TBCP_ADDR_AUX_COUNT:  rd_data <= aux_count_r;
               `TBCP_ADDR_CORE_COUNT: rd_data <= core_count_r;
               `TBCP_ADDR_AUX_CTRL:   rd_data <= aux_ctrl_r;
               `TBCP_ADDR_CORE_CTRL:  rd_data <= core_ctrl_r;
               `TBCP_ADDR_STATUS:     rd_data <= status;
               default:               rd_data <= `TBCP_READ_IDLE;
            endcase
         end
         else
            rd_data <= `TBCP_READ_IDLE;
      end
   end

endmodule
`default_nettype wire

// ==== test/tbcp_top_asserts.sv ====
// Concurrent checks on the ports of the timer block clock front end
`timescale 1ns/1ps
`default_nettype none
module tbcp_top_asserts
   import tbcp_pkg::*;
#(
   parameter int unsigned DIV_W = 7
)
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire tbcp_req_s   bus_req,
   input wire logic        aux_in,
   input wire logic        core_in,
   input wire logic        capture_in,
   input wire logic [15:0] rd_data,
   input wire logic        basic_tick_o,
   input wire logic        aux_count_tick,
   input wire logic        core_count_tick,
   input wire logic        aux_edge_event,
   input wire logic        core_edge_event,
   input wire logic        capture_event
);
   // --------------------
   // Pin quiet time
   // --------------------
   // Worst path pin to event is about 20 clocks, so 32 leaves margin
   wire logic [2:0] pins = {capture_in, core_in, aux_in};
   logic [2:0]      pin_r;
   logic [5:0]      q_r [3];
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_r <= 3'h0;
         q_r   <= '{6'h3f, 6'h3f, 6'h3f};
      end
      else
      begin
         pin_r <= pins;
         for (int i = 0; i < 3; i++)
            q_r[i] <= (pins[i] != pin_r[i]) ? 6'h0 : q_r[i] + {5'h0, q_r[i] != 6'h3f};
      end
   end
   default clocking dc @(posedge clk);
   endclocking
   // Frozen outputs while the clock enable is low are not a fault
   default disable iff (!rst_n || !ce);
   tick_gap_a: assert property (basic_tick_o |=> !basic_tick_o)
      else $error("basic tick closer than two clocks");
   tick_bound_a: assert property (basic_tick_o |-> ##[1:16] basic_tick_o)
      else $error("basic tick later than sixteen clocks");
   sample_tick_a: assert property ((aux_edge_event || core_edge_event || capture_event) |-> $past(basic_tick_o))
      else $error("edge event not aligned to basic tick");
   aux_cause_a: assert property (aux_edge_event |-> q_r[0] < 6'h20)
      else $error("aux event without pin change");
   core_cause_a: assert property (core_edge_event |-> q_r[1] < 6'h20)
      else $error("core event without pin change");
   cap_cause_a: assert property (capture_event |-> q_r[2] < 6'h20)
      else $error("capture event without pin change");
   count_gap_a: assert property (aux_count_tick |=> !aux_count_tick)
      else $error("aux count ticks back to back");
   rd_idle_a: assert property (rd_data != 16'h0 |-> $past(bus_req.rd))
      else $error("read data outside read slot");
   cover property (capture_event);
   cover property (core_count_tick);
   cover property (aux_edge_event);
   cover property (bus_req.rd ##1 rd_data != 16'h0);
endmodule
bind tbcp_top tbcp_top_asserts #(.DIV_W(DIV_W)) tbcp_top_asserts_i (
   .clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req), .aux_in(aux_in),
   .core_in(core_in), .capture_in(capture_in), .rd_data(rd_data),
   .basic_tick_o(basic_tick_o), .aux_count_tick(aux_count_tick),
   .core_count_tick(core_count_tick), .aux_edge_event(aux_edge_event),
   .core_edge_event(core_edge_event), .capture_event(capture_event));
`default_nettype wire

// ==== test/tbcp_pin_model.sv ====
// External pin source driving the three timer inputs
`timescale 1ns/1ps
`default_nettype none
module tbcp_pin_model
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [4:0] hold,
   input  wire logic [4:0] toggles,
   output logic      [2:0] pins
);
   // --------------------
   // Toggle engine
   // --------------------
   // Each level stands exactly hold clocks, the shortest legal time
   logic [4:0] left_r;
   logic [4:0] cnt_r;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pins   <= 3'h0;
         left_r <= 5'h0;
         cnt_r  <= 5'h0;
      end
      else if (go)
      begin
         left_r <= toggles;
         cnt_r  <= hold - 5'h1;
      end
      else if (left_r != 5'h0)
      begin
         if (cnt_r == 5'h0)
         begin
            pins   <= ~pins;
            left_r <= left_r - 5'h1;
            cnt_r  <= hold - 5'h1;
         end
         else
            cnt_r <= cnt_r - 5'h1;
      end
   end
endmodule
`default_nettype wire

// ==== test/tbcp_top_tb.sv ====
// Self-checking bench for the timer block clock front end
`timescale 1ns/1ps
`default_nettype none
`include "tbcp_params.svh"
module tbcp_top_tb;
   import tbcp_pkg::*;
   logic        clk, rst_n, go, ce;
   tbcp_req_s   req;
   logic [2:0]  pins;
   logic [4:0]  hold, togs;
   logic [15:0] rdd;
   logic        tick, a_tk, c_tk, a_ev, c_ev, p_ev;
   int          bad_count, tests_run, n_a, n_c, n_p, n_at, n_ct;
   tbcp_top tbcp_top_i (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_req(req),
      .aux_in(pins[0]), .core_in(pins[1]), .capture_in(pins[2]), .rd_data(rdd),
      .basic_tick_o(tick), .aux_count_tick(a_tk), .core_count_tick(c_tk),
      .aux_edge_event(a_ev), .core_edge_event(c_ev), .capture_event(p_ev));
   tbcp_pin_model tbcp_pin_model_i (.clk(clk), .rst_n(rst_n), .go(go),
      .hold(hold), .toggles(togs), .pins(pins));
   // --------------------
   // Helpers
   // --------------------
   always @(negedge clk)
   begin
      n_a += a_ev;
      n_c += c_ev;
      n_p += p_ev;
      n_at += a_tk;
      n_ct += c_tk;
   end
   task automatic clr;
      n_a = 0;
      n_c = 0;
      n_p = 0;
      n_at = 0;
      n_ct = 0;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [15:0] ctl(logic [2:0] ip, logic [1:0] md, logic [1:0] es,
                                      logic r, logic [1:0] cp, logic [1:0] bps);
      return {3'h0, bps, cp, r, 1'b0, es, md, ip};
   endfunction
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk);
      req <= '{a, 16'h0, 1'b0, 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 chk(rdd, e);
   endtask
   function automatic logic pick(input int s);
      return s == 0 ? tick : (s == 1 ? a_tk : c_tk);
   endfunction
   task automatic wt(input int s, output int p);
      p = 0;
      do
      begin
         @(negedge clk);
         p++;
      end
      while (pick(s) !== 1'b1 && p < 4000);
      if (p >= 4000)
      begin
         bad_count++;
         $display("[FAIL] %0t wait for tick timed out", $time);
         complete_run;
      end
   endtask
   // First interval may be cut short by a setting change, so time the second
   task automatic gap(input int s, input int e);
      int p;
      wt(s, p);
      wt(s, p);
      chk(16'(p), 16'(e));
   endtask
   // --------------------
   // Scenarios
   // --------------------
   task automatic t_regs;
      gap(0, 4);
      rd(`TBCP_ADDR_CORE_CTRL, 16'h0);
      rd(`TBCP_ADDR_AUX_COUNT, 16'h0);
      rd(16'hfe4e, 16'h0);
      wr(`TBCP_ADDR_AUX_CTRL, 16'hffff);
      rd(`TBCP_ADDR_AUX_CTRL, `TBCP_AUX_CTRL_WMASK);
      wr(`TBCP_ADDR_AUX_CTRL, 16'h0);
      wr(`TBCP_ADDR_CORE_COUNT, 16'h1234);
      rd(`TBCP_ADDR_CORE_COUNT, 16'h1234);
      $display("t_regs done");
   endtask
   task automatic t_pre;
      logic [1:0] b [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
      logic [2:0] ip [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
      int e [4] = '{2, 8, 64, 2048};
      for (int i = 0; i < 4; i++)
      begin
         wr(`TBCP_ADDR_CORE_CTRL, ctl(3'h0, TBCP_MODE_TIMER, 2'h0, 1'b0, 2'h0, b[i]));
         gap(0, 2 << i);
         wr(`TBCP_ADDR_CORE_CTRL, ctl(ip[i], TBCP_MODE_TIMER, 2'h0, 1'b1, 2'h0, b[i]));
         wr(`TBCP_ADDR_AUX_CTRL, ctl(ip[i], TBCP_MODE_TIMER, 2'h0, 1'b1, 2'h0, 2'h0));
         gap(2, e[i]);
         gap(1, e[i]);
      end
      $display("t_pre done");
   endtask
   task automatic t_cnt;
      logic [15:0] x;
      for (int es = 1; es < 4; es++)
      begin
         x = (es == 3) ? 16'h8 : 16'h4;
         // Counter mode first, so no timer-mode tick slips in after the clear
         wr(`TBCP_ADDR_AUX_CTRL, ctl(3'h0, TBCP_MODE_COUNTER, 2'(es), 1'b1, 2'(es), 2'h0));
         wr(`TBCP_ADDR_CORE_CTRL, ctl(3'h0, TBCP_MODE_COUNTER, 2'(es), 1'b1, 2'h0, 2'h1));
         wr(`TBCP_ADDR_AUX_COUNT, 16'h0);
         clr;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (60) @(posedge clk);
         chk(16'(n_a), x);
         chk(16'(n_c), x);
         chk(16'(n_p), x);
         chk(16'(n_at), x);
         rd(`TBCP_ADDR_AUX_COUNT, x);
      end
      $display("t_cnt done");
   endtask
   task automatic t_gate;
      wr(`TBCP_ADDR_CORE_CTRL, ctl(3'h0, TBCP_MODE_GATED_HI, 2'h0, 1'b1, 2'h0, 2'h1));
      clr;
      repeat (64) @(posedge clk);
      chk(16'(n_ct), 16'h0);
      wr(`TBCP_ADDR_CORE_CTRL, ctl(3'h0, TBCP_MODE_GATED_LO, 2'h0, 1'b1, 2'h0, 2'h1));
      repeat (8) @(posedge clk);
      clr;
      repeat (64) @(posedge clk);
      chk(16'(n_ct), 16'h20);
      // Pins go high and stay there
      togs <= 5'h1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (16) @(posedge clk);
      rd(`TBCP_ADDR_STATUS, 16'h7);
      clr;
      repeat (64) @(posedge clk);
      chk(16'(n_ct), 16'h0);
      wr(`TBCP_ADDR_CORE_CTRL, ctl(3'h0, TBCP_MODE_GATED_HI, 2'h0, 1'b1, 2'h0, 2'h1));
      repeat (8) @(posedge clk);
      clr;
      repeat (64) @(posedge clk);
      chk(16'(n_ct), 16'h20);
      $display("t_gate done");
   endtask
   // Clock enable low must freeze the count tick at its last value
   task automatic t_ce;
      logic v;
      ce <= 1'b0;
      @(posedge clk);
      v = c_tk;
      clr;
      repeat (40) @(posedge clk);
      chk(16'(n_ct), v ? 16'h28 : 16'h0);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      $display("t_ce done");
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      rst_n = 1'b0;
      req = '0;
      go = 1'b0;
      ce = 1'b1;
      hold = 5'h2;
      togs = 5'h8;
      bad_count = 0;
      tests_run = 0;
      clr;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_pre;
      t_cnt;
      t_gate;
      t_ce;
      complete_run;
   end
endmodule
`default_nettype wire
